// file: rtl/dpl_limiter.sv
// Sample FIFO and dual peak limiter with its control registers.
`timescale 1ns/1ps

module dpl_fifo
    import dpl_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic mclk, // System clock.
    input wire logic reset_n, // Asynchronous reset, active low.
    input wire logic inValid, // Writer offers a word.
    output logic inReady, // FIFO has room.
    input wire logic [WIDTH-1:0] inData, // Word to store.
    output logic outValid, // FIFO holds a word.
    input wire logic outReady, // Reader takes the word.
    output logic [WIDTH-1:0] outData // Oldest word.
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] DEPTH_CNT = (AW + 1)'(DEPTH);
    localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wrPtr;
        logic [AW-1:0] rdPtr;
        logic [AW:0] count;
        logic readyFlag;
        logic validFlag;
    } dpl_fifo_state_s;
    // Ready is kept as its own flop so the writer sees a registered signal, high in reset.
    localparam dpl_fifo_state_s FIFO_RST = '{readyFlag: 1'b1, default: '0};
    dpl_fifo_state_s st_ff;
    dpl_fifo_state_s nxt_st;
    logic push;
    logic pop;

    assign inReady = st_ff.readyFlag;
    assign outValid = st_ff.validFlag;
    assign outData = st_ff.mem[st_ff.rdPtr];

    always_comb begin
        nxt_st = st_ff;
        push = inValid && st_ff.readyFlag;
        pop = outReady && st_ff.validFlag;
        if (push) begin
            nxt_st.mem[st_ff.wrPtr] = inData;
            nxt_st.wrPtr = (st_ff.wrPtr == LAST_PTR) ? '0 : st_ff.wrPtr + 1'b1;
        end
        if (pop) begin
            nxt_st.rdPtr = (st_ff.rdPtr == LAST_PTR) ? '0 : st_ff.rdPtr + 1'b1;
        end
        if (push && !pop) begin
            nxt_st.count = st_ff.count + 1'b1;
        end else if (pop && !push) begin
            nxt_st.count = st_ff.count - 1'b1;
        end
        nxt_st.readyFlag = (nxt_st.count != DEPTH_CNT);
        nxt_st.validFlag = (nxt_st.count != '0);
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            st_ff <= FIFO_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end
endmodule

module dpl_limiter_top
    import dpl_pkg::*;
(
    input wire logic mclk, // System clock, 50 MHz.
    input wire logic reset_n, // Asynchronous reset, active low.
    input wire dpl_regreq_s regReq, // Register access from the control port.
    output logic [7:0] regRdData, // Read data, valid the cycle after a read.
    input wire logic inValid, // Frame of eight samples offered.
    output logic inReady, // Frame accepted when high with inValid.
    input wire dpl_frame_s inFrame, // Volume-scaled samples with headroom.
    output logic outValid, // Limited frame available.
    input wire logic outReady, // Downstream takes the frame.
    output dpl_out_s outFrame // Limited and saturated samples.
);
    dpl_top_state_s st_ff;
    dpl_top_state_s nxt_st;
    logic fifoValid;
    dpl_frame_s fifoData;
    logic pop;
    logic [1:0][SW-1:0] peakMag;
    logic [1:0][7:0] loudVol;
    logic signed [17:0] peakCb [2];
    logic signed [17:0] attCb [2];
    logic signed [17:0] relCb [2];
    logic [1:0] over;
    logic [1:0] under;

    function automatic logic [1:0] mapCode(input logic [15:0] map, input int ch);
        return map[2*ch +: 2];
    endfunction

    function automatic logic [1:0] limCode(input int l);
        return (l == 0) ? MAP_ONE : MAP_TWO;
    endfunction

    function automatic logic [SW-1:0] absMag(input logic [SW-1:0] s);
        return s[SW-1] ? (~s + 1'b1) : s;
    endfunction

    function automatic logic [OW-1:0] satOut(input logic [SW-1:0] s);
        logic [SW-OW:0] top;
        top = s[SW-1:OW-1];
        if ((&top) || !(|top)) begin
            return s[OW-1:0];
        end
        return s[SW-1] ? {1'b1, {(OW-1){1'b0}}} : {1'b0, {(OW-1){1'b1}}};
    endfunction

    // Coarse log: whole bits at 6.02 dB plus four bits of linear fraction.
    function automatic logic signed [17:0] levelCb(input logic [SW-1:0] mag);
        int p;
        logic [SW-1:0] norm;
        int frac;
        p = -1;
        for (int i = 0; i < SW; i++) begin
            if (mag[i]) begin
                p = i;
            end
        end
        if (p < 0) begin
            return LEVEL_SILENT;
        end
        norm = mag << (SW - 1 - p);
        frac = int'(norm[SW-2 -: 4]);
        return 18'((p - FS_BIT) * BIT_CB + (frac * BIT_CB) / 16);
    endfunction

    function automatic logic [SW-1:0] applyAttn(input logic [SW-1:0] s,
                                                input logic [31:0] attn);
        int sh;
        sh = int'(attn / 32'(ATTN_PER_BIT));
        if (sh > SW - 1) begin
            sh = SW - 1;
        end
        return $signed(s) >>> sh;
    endfunction

    dpl_fifo #(
        .WIDTH($bits(dpl_frame_s)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .mclk(mclk),
        .reset_n(reset_n),
        .inValid(inValid),
        .inReady(inReady),
        .inData(inFrame),
        .outValid(fifoValid),
        .outReady(pop),
        .outData(fifoData)
    );

    assign regRdData = st_ff.rdData;
    assign outValid = st_ff.outValid;
    assign outFrame = st_ff.outData;

    always_comb begin
        logic [1:0] code;
        logic [3:0] attCode;
        logic [3:0] relCode;
        logic [32:0] sum;
        logic [15:0] cRate;
        logic [15:0] rRate;
        logic signed [17:0] volCb;
        code = MAP_NONE;
        attCode = '0;
        relCode = '0;
        sum = '0;
        cRate = '0;
        rRate = '0;
        volCb = '0;
        nxt_st = st_ff;
        pop = fifoValid && (!st_ff.outValid || outReady);
        if (st_ff.outValid && outReady) begin
            nxt_st.outValid = 1'b0;
        end
        if (regReq.wr) begin
            case (regReq.addr)
                ADDR_CONF_B: nxt_st.mode = regReq.wdata[MODE_BIT];
                ADDR_CONF_E: nxt_st.volume_dynamics_enable = regReq.wdata[VOLUME_DYNAMICS_ENABLE_BIT];
                ADDR_MAP_LO: nxt_st.map[7:0] = regReq.wdata;
                ADDR_MAP_HI: nxt_st.map[15:8] = regReq.wdata;
                ADDR_L1_RATE: nxt_st.rate[0] = regReq.wdata;
                ADDR_L1_THR: nxt_st.thr[0] = regReq.wdata;
                ADDR_L2_RATE: nxt_st.rate[1] = regReq.wdata;
                ADDR_L2_THR: nxt_st.thr[1] = regReq.wdata;
                default: begin
                    if (regReq.addr >= ADDR_VOL_FIRST && regReq.addr <= ADDR_VOL_LAST) begin
                        nxt_st.vol[3'(regReq.addr - ADDR_VOL_FIRST)] = regReq.wdata;
                    end
                end
            endcase
        end
        if (regReq.rd) begin
            case (regReq.addr)
                ADDR_CONF_B: nxt_st.rdData = {st_ff.mode, 7'h00};
                ADDR_CONF_E: nxt_st.rdData = {6'h00, st_ff.volume_dynamics_enable, 1'b0};
                ADDR_MAP_LO: nxt_st.rdData = st_ff.map[7:0];
                ADDR_MAP_HI: nxt_st.rdData = st_ff.map[15:8];
                ADDR_L1_RATE: nxt_st.rdData = st_ff.rate[0];
                ADDR_L1_THR: nxt_st.rdData = st_ff.thr[0];
                ADDR_L2_RATE: nxt_st.rdData = st_ff.rate[1];
                ADDR_L2_THR: nxt_st.rdData = st_ff.thr[1];
                default: begin
                    nxt_st.rdData = 8'h00;
                    if (regReq.addr >= ADDR_VOL_FIRST && regReq.addr <= ADDR_VOL_LAST) begin
                        nxt_st.rdData = st_ff.vol[3'(regReq.addr - ADDR_VOL_FIRST)];
                    end
                end
            endcase
        end
        // Code 11 matches neither limiter, so a misprogrammed channel stays unlimited.
        for (int l = 0; l < 2; l++) begin
            peakMag[l] = '0;
            loudVol[l] = 8'hFF;
            for (int ch = 0; ch < NCH; ch++) begin
                if (mapCode(st_ff.map, ch) == limCode(l)) begin
                    if (absMag(fifoData.smp[ch]) > peakMag[l]) begin
                        peakMag[l] = absMag(fifoData.smp[ch]);
                    end
                    if (st_ff.vol[ch] < loudVol[l]) begin
                        loudVol[l] = st_ff.vol[ch];
                    end
                end
            end
            peakCb[l] = levelCb(peakMag[l]);
            attCode = st_ff.thr[l][7:4];
            relCode = st_ff.thr[l][3:0];
            volCb = 18'((VOL_ZERO_CODE - int'(loudVol[l])) * VOL_STEP_CB);
            if (!st_ff.mode) begin
                attCb[l] = AC_ATT_CB[attCode];
                relCb[l] = AC_REL_CB[relCode];
            end else begin
                attCb[l] = volCb + DRC_ATT_CB[attCode];
                relCb[l] = (relCode == 4'h0) ? THR_POS_INF
                                             : attCb[l] + DRC_REL_CB[relCode];
            end
            over[l] = (peakCb[l] > attCb[l]);
            under[l] = (peakCb[l] < relCb[l]);
            cRate = COMP_RATE[st_ff.rate[l][3:0]];
            rRate = REL_RATE[st_ff.rate[l][7:4]];
            if (pop) begin
                if (!st_ff.volume_dynamics_enable) begin
                    nxt_st.attn[l] = '0;
                end else if (over[l]) begin
                    sum = {1'b0, st_ff.attn[l]} + {17'h00000, cRate};
                    nxt_st.attn[l] = (sum > {1'b0, ATTN_MAX}) ? ATTN_MAX : sum[31:0];
                end else if (under[l]) begin
                    nxt_st.attn[l] = (st_ff.attn[l] > {16'h0000, rRate})
                                   ? st_ff.attn[l] - {16'h0000, rRate} : '0;
                end
            end
        end
        if (pop) begin
            nxt_st.outValid = 1'b1;
            for (int ch = 0; ch < NCH; ch++) begin
                code = mapCode(st_ff.map, ch);
                if (st_ff.volume_dynamics_enable && code == MAP_ONE) begin
                    nxt_st.outData.smp[ch] = satOut(applyAttn(fifoData.smp[ch],
                                                              st_ff.attn[0]));
                end else if (st_ff.volume_dynamics_enable && code == MAP_TWO) begin
                    nxt_st.outData.smp[ch] = satOut(applyAttn(fifoData.smp[ch],
                                                              st_ff.attn[1]));
                end else begin
                    nxt_st.outData.smp[ch] = satOut(fifoData.smp[ch]);
                end
            end
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            st_ff.map <= MAP_RST;
            st_ff.rate <= {RATE_RST, RATE_RST};
            st_ff.thr <= {THR_RST, THR_RST};
            st_ff.mode <= MODE_RST;
            st_ff.volume_dynamics_enable <= VOLUME_DYNAMICS_ENABLE_RST;
            st_ff.vol <= {NCH{VOL_RST}};
            st_ff.attn <= '0;
            st_ff.outValid <= 1'b0;
            st_ff.outData <= '0;
            st_ff.rdData <= 8'h00;
        end else begin
            st_ff <= nxt_st;
        end
    end

    map_reset_a: assert property (@(posedge mclk) disable iff (!reset_n)
        !$past(reset_n) |-> st_ff.map == MAP_RST)
        else $error("Channel assignments not cleared after reset.");

    rate_reset_a: assert property (@(posedge mclk) disable iff (!reset_n)
        !$past(reset_n) |-> st_ff.rate[0] == RATE_RST && st_ff.thr[1] == THR_RST)
        else $error("Limiter rate or threshold reset value wrong.");

    unmapped_pass_a: assert property (@(posedge mclk) disable iff (!reset_n)
        pop && mapCode(st_ff.map, 0) == MAP_NONE
        |=> st_ff.outData.smp[0] == satOut($past(fifoData.smp[0])))
        else $error("Unassigned channel was gain reduced.");

    attack_ramp_a: assert property (@(posedge mclk) disable iff (!reset_n)
        pop && st_ff.volume_dynamics_enable && over[0]
        |=> st_ff.attn[0] > $past(st_ff.attn[0]) || st_ff.attn[0] == ATTN_MAX)
        else $error("Gain not reduced while over attack threshold.");

    release_ramp_a: assert property (@(posedge mclk) disable iff (!reset_n)
        pop && st_ff.volume_dynamics_enable && !over[0] && under[0]
        |=> st_ff.attn[0] < $past(st_ff.attn[0]) || st_ff.attn[0] == '0)
        else $error("Gain not restored below release threshold.");

    gain_hold_a: assert property (@(posedge mclk) disable iff (!reset_n)
        pop && st_ff.volume_dynamics_enable && !over[1] && !under[1] |=> $stable(st_ff.attn[1]))
        else $error("Gain moved between the two thresholds.");

    bypass_clear_a: assert property (@(posedge mclk) disable iff (!reset_n)
        pop && !st_ff.volume_dynamics_enable |=> st_ff.attn[0] == '0 && st_ff.attn[1] == '0)
        else $error("Limiting active while bypassed.");

    rate_readback_a: assert property (@(posedge mclk) disable iff (!reset_n)
        regReq.rd && regReq.addr == ADDR_L1_RATE |=> regRdData == $past(st_ff.rate[0]))
        else $error("Limiter one rate register read back wrong.");

    separate_sets_a: assert property (@(posedge mclk) disable iff (!reset_n)
        regReq.wr && regReq.addr == ADDR_L2_RATE |=> $stable(st_ff.rate[0]))
        else $error("Limiter two write disturbed limiter one.");

    compress_step_a: assert property (@(posedge mclk) disable iff (!reset_n)
        pop && st_ff.volume_dynamics_enable && over[0] && st_ff.rate[0][3:0] == 4'h0
            && st_ff.attn[0] <= ATTN_MAX - 32'(COMP_RATE[0])
        |=> st_ff.attn[0] == $past(st_ff.attn[0]) + 32'(COMP_RATE[0]))
        else $error("Fastest compression step not applied.");

    bypass_pass_a: assert property (@(posedge mclk) disable iff (!reset_n)
        pop && !st_ff.volume_dynamics_enable |=> st_ff.outData.smp[1] == satOut($past(fifoData.smp[1])))
        else $error("Bypassed channel was gain reduced.");

    rate_two_readback_a: assert property (@(posedge mclk) disable iff (!reset_n)
        regReq.rd && regReq.addr == ADDR_L2_RATE |=> regRdData == $past(st_ff.rate[1]))
        else $error("Limiter two rate register read back wrong.");
endmodule

// file: rtl/dpl_pkg.sv
// Constants, tables and carrier types for the dual peak limiter.
package dpl_pkg;
    localparam int NCH = 8;
    localparam int SW = 28;
    localparam int OW = 24;
    localparam int FIFO_DEPTH = 8;
    localparam logic [7:0] ADDR_CONF_B = 8'h01;
    localparam logic [7:0] ADDR_CONF_E = 8'h04;
    localparam logic [7:0] ADDR_VOL_FIRST = 8'h09;
    localparam logic [7:0] ADDR_VOL_LAST = 8'h10;
    localparam logic [7:0] ADDR_MAP_LO = 8'h15;
    localparam logic [7:0] ADDR_MAP_HI = 8'h16;
    localparam logic [7:0] ADDR_L1_RATE = 8'h17;
    localparam logic [7:0] ADDR_L1_THR = 8'h18;
    localparam logic [7:0] ADDR_L2_RATE = 8'h19;
    localparam logic [7:0] ADDR_L2_THR = 8'h1A;
    localparam int MODE_BIT = 7;
    localparam int VOLUME_DYNAMICS_ENABLE_BIT = 1;
    localparam logic [15:0] MAP_RST = 16'h0000;
    localparam logic [7:0] RATE_RST = 8'hA6;
    localparam logic [7:0] THR_RST = 8'h67;
    localparam logic [7:0] VOL_RST = 8'h30;
    localparam logic MODE_RST = 1'b0;
    localparam logic VOLUME_DYNAMICS_ENABLE_RST = 1'b1;
    localparam logic [1:0] MAP_NONE = 2'h0;
    localparam logic [1:0] MAP_ONE = 2'h1;
    localparam logic [1:0] MAP_TWO = 2'h2;
    // Sample rate in kHz sets the gain step per sample from a rate in dB/ms.
    localparam int FS_KHZ = 48;
    // Attenuation is kept in units of 0.0001 dB / FS_KHZ; one centi-dB is this many.
    localparam int CB_UNITS = 100 * FS_KHZ;
    localparam int BIT_CB = 602;
    localparam int ATTN_PER_BIT = BIT_CB * CB_UNITS;
    localparam logic [31:0] ATTN_MAX = 32'h02DC6C00;
    localparam int FS_BIT = OW - 1;
    localparam int VOL_ZERO_CODE = 48;
    localparam int VOL_STEP_CB = 50;
    localparam logic signed [17:0] LEVEL_SILENT = -18'sd32000;
    localparam logic signed [17:0] THR_NEG_INF = -18'sd32768;
    localparam logic signed [17:0] THR_POS_INF = 18'sd32767;
    // Rates in 0.0001 dB/ms, thresholds in centi-dB, indexed by field code.
    localparam logic [15:0] COMP_RATE [16] = '{16'd31584, 16'd27072, 16'd22560,
        16'd18048, 16'd13536, 16'd9024, 16'd4512, 16'd2256, 16'd1504, 16'd1123,
        16'd902, 16'd752, 16'd645, 16'd564, 16'd501, 16'd451};
    localparam logic [15:0] REL_RATE [16] = '{16'd5116, 16'd1370, 16'd744, 16'd499,
        16'd360, 16'd299, 16'd264, 16'd208, 16'd198, 16'd172, 16'd147, 16'd137,
        16'd134, 16'd117, 16'd110, 16'd104};
    localparam logic signed [17:0] AC_ATT_CB [16] = '{-18'sd1200, -18'sd1000,
        -18'sd800, -18'sd600, -18'sd400, -18'sd200, 18'sd0, 18'sd200, 18'sd300,
        18'sd400, 18'sd500, 18'sd600, 18'sd700, 18'sd800, 18'sd900, 18'sd1000};
    localparam logic signed [17:0] AC_REL_CB [16] = '{-18'sd32768, -18'sd2300,
        -18'sd1690, -18'sd1340, -18'sd1090, -18'sd900, -18'sd740, -18'sd600,
        -18'sd490, -18'sd380, -18'sd290, -18'sd210, -18'sd130, -18'sd65, 18'sd0,
        18'sd60};
    localparam logic signed [17:0] DRC_ATT_CB [16] = '{-18'sd2200, -18'sd2000,
        -18'sd1800, -18'sd1600, -18'sd1400, -18'sd1200, -18'sd1000, -18'sd800,
        -18'sd700, -18'sd600, -18'sd500, -18'sd400, -18'sd300, -18'sd200,
        -18'sd100, 18'sd0};
    localparam logic signed [17:0] DRC_REL_CB [16] = '{18'sd32767, -18'sd3300,
        -18'sd2690, -18'sd2340, -18'sd2090, -18'sd1900, -18'sd1740, -18'sd1600,
        -18'sd1490, -18'sd1380, -18'sd1290, -18'sd1210, -18'sd1130, -18'sd1065,
        -18'sd1000, -18'sd940};
    typedef struct packed {
        logic [NCH-1:0][SW-1:0] smp;
    } dpl_frame_s;
    typedef struct packed {
        logic [NCH-1:0][OW-1:0] smp;
    } dpl_out_s;
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } dpl_regreq_s;
    typedef struct packed {
        logic [15:0] map;
        logic [1:0][7:0] rate;
        logic [1:0][7:0] thr;
        logic mode;
        logic volume_dynamics_enable;
        logic [NCH-1:0][7:0] vol;
        logic [1:0][31:0] attn;
        logic outValid;
        dpl_out_s outData;
        logic [7:0] rdData;
    } dpl_top_state_s;
endpackage

// file: tb/dpl_sink_model.sv
// Downstream sink model that takes limited frames with random or forced stalls.
`timescale 1ns/1ps
module dpl_sink_model (
    input wire logic mclk, // System clock.
    input wire logic reset_n, // Reset, active low.
    input wire logic hold, // Bench forces a long stall.
    output logic outReady // Frame taken when high.
);
    // Ready moves at the falling edge so it is settled well before the sampling edge.
    always @(negedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            outReady <= 1'b0;
        end else begin
            outReady <= !hold && ($urandom % 4 != 0);
        end
    end
endmodule

// file: tb/tb_dual_peak_limiter.sv
// Self-checking bench for the dual peak limiter.
`timescale 1ns/1ps
module tb_dual_peak_limiter;
    import dpl_pkg::*;
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    dpl_regreq_s regReq = '0;
    logic [7:0] regRdData;
    logic inValid = 1'b0;
    logic inReady;
    dpl_frame_s inFrame = '0;
    logic outValid;
    logic outReady;
    dpl_out_s outFrame;
    logic hold = 1'b0;
    int n_errors = 0;
    int tests_run = 0;
    dpl_out_s expQ[$];
    int attn1 = 0;
    int rate1 = 0;
    logic volume_dynamics_enable = 1'b1;
    int cnt;
    logic [7:0] v;

    always #10 mclk = ~mclk;

    dpl_limiter_top uut (.mclk(mclk), .reset_n(reset_n), .regReq(regReq),
        .regRdData(regRdData), .inValid(inValid), .inReady(inReady), .inFrame(inFrame),
        .outValid(outValid), .outReady(outReady), .outFrame(outFrame));
    dpl_sink_model sink (.mclk(mclk), .reset_n(reset_n), .hold(hold), .outReady(outReady));

    task automatic report_and_stop();
        if (n_errors == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cmp_frame(input dpl_out_s got, input dpl_out_s exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk);
        regReq <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge mclk);
        regReq <= '0;
    endtask

    task automatic reg_check(input logic [7:0] a, input logic [7:0] exp);
        @(negedge mclk);
        regReq <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(negedge mclk);
        regReq <= '0;
        cmp8(regRdData, exp);
    endtask

    function automatic logic [OW-1:0] sat(input logic signed [SW-1:0] s);
        if (s > 28'sh07FFFFF) return 24'h7FFFFF;
        if (s < -28'sh0800000) return 24'h800000;
        return s[OW-1:0];
    endfunction

    // Channels one and two sit at half scale, so their peak level is fixed and known.
    function automatic dpl_frame_s rnd_frame();
        dpl_frame_s f;
        for (int i = 0; i < NCH; i++) begin
            f.smp[i] = SW'($urandom_range(32'h3FFFFFF) - 32'h2000000);
        end
        f.smp[0] = $urandom_range(1) ? 28'h0400000 : 28'hFC00000;
        f.smp[1] = $urandom_range(1) ? 28'h0400000 : 28'hFC00000;
        return f;
    endfunction

    task automatic push(input dpl_frame_s f);
        dpl_out_s e;
        int sh;
        sh = volume_dynamics_enable ? attn1 / ATTN_PER_BIT : 0;
        for (int i = 0; i < NCH; i++) begin
            e.smp[i] = sat((i == 0) ? ($signed(f.smp[i]) >>> sh) : $signed(f.smp[i]));
        end
        if (volume_dynamics_enable) attn1 = attn1 + rate1;
        @(negedge mclk);
        inValid <= 1'b1;
        inFrame <= f;
        @(posedge mclk);
        while (inReady !== 1'b1) @(posedge mclk);
        expQ.push_back(e);
        @(negedge mclk);
        inValid <= 1'b0;
    endtask

    task automatic drain();
        cnt = 0;
        while (expQ.size() != 0 && cnt < 3000) begin
            @(negedge mclk);
            cnt++;
        end
        cmp8(8'(expQ.size()), 8'h00);
    endtask

    always @(posedge mclk) begin
        if (reset_n && outValid === 1'b1 && outReady === 1'b1) begin
            if (expQ.size() == 0) cmp8(8'hFF, 8'h00);
            else cmp_frame(outFrame, expQ.pop_front());
        end
    end

    initial begin
        #(20 * 30000);
        n_errors++;
        report_and_stop();
    end

    initial begin
        v = 8'($urandom(28585));
        repeat (12) @(posedge mclk);
        @(negedge mclk);
        reset_n = 1'b1;
        reg_check(ADDR_MAP_LO, 8'h00);
        reg_check(ADDR_MAP_HI, 8'h00);
        reg_check(ADDR_L1_RATE, 8'hA6);
        reg_check(ADDR_L2_RATE, 8'hA6);
        reg_check(ADDR_L1_THR, 8'h67);
        reg_check(ADDR_L2_THR, 8'h67);
        reg_check(ADDR_CONF_B, 8'h00);
        reg_check(ADDR_CONF_E, 8'h02);
        reg_check(8'h0C, 8'h30);
        reg_write(8'h2D, 8'h5A);
        reg_check(8'h2D, 8'h00);
        reg_write(ADDR_CONF_B, 8'hFF);
        reg_check(ADDR_CONF_B, 8'h80);
        reg_write(ADDR_CONF_B, 8'h00);
        for (int k = 0; k < 6; k++) begin
            v = 8'($urandom);
            v = v & ~(((v >> 1) & v) & 8'h55);
            reg_write(ADDR_MAP_HI, v);
            reg_check(ADDR_MAP_HI, v);
            reg_write(ADDR_L2_RATE, ~v);
            reg_check(ADDR_L2_RATE, ~v);
        end
        reg_write(ADDR_MAP_HI, 8'h00);
        repeat (20) push(rnd_frame());
        drain();
        // Channel one on the first limiter, channel two on the second, the rest unlimited.
        reg_write(ADDR_MAP_LO, 8'h09);
        reg_write(ADDR_L1_THR, 8'h00);
        reg_write(ADDR_L1_RATE, 8'hA0);
        // Half scale on channel two sits between these thresholds, so its gain must hold.
        reg_write(ADDR_L2_THR, 8'h66);
        rate1 = 31584;
        repeat (200) push(rnd_frame());
        drain();
        reg_write(ADDR_CONF_E, 8'h00);
        volume_dynamics_enable = 1'b0;
        attn1 = 0;
        repeat (20) push(rnd_frame());
        drain();
        reg_write(ADDR_CONF_E, 8'h02);
        volume_dynamics_enable = 1'b1;
        @(negedge mclk);
        hold <= 1'b1;
        repeat (3) @(negedge mclk);
        cnt = 0;
        while (inReady === 1'b1 && cnt < 12) begin
            push(rnd_frame());
            cnt++;
        end
        cmp8(8'(cnt), 8'h09);
        hold <= 1'b0;
        drain();
        // Compression mode: attack code F is over half scale only through the -12 dB volume.
        reg_write(ADDR_MAP_LO, 8'h01);
        reg_write(ADDR_CONF_B, 8'h80);
        reg_write(ADDR_L1_THR, 8'hFE);
        reg_write(ADDR_VOL_FIRST, 8'h48);
        repeat (100) push(rnd_frame());
        drain();
        report_and_stop();
    end
endmodule
